// ### verilog/brf_pkg.sv
// Constants and carrier types of the banked general register file
package brf_pkg;

   // ==========================================================
   // Geometry
   localparam int BANKS      = 8;
   localparam int BYTES      = 16;
   localparam int PAIRS      = 8;
   localparam int EXTS       = 4;
   localparam int BANK_W     = 3;
   localparam int IDX_W      = 4;
   localparam int SLOT_W     = BANK_W + IDX_W;
   localparam int EXT_SLOT_W = BANK_W + 2;
   localparam int DATA_W     = 8;
   localparam int WORD_W     = 16;
   localparam int WIDE_W     = 24;
   localparam int QUAD_W     = 32;
   localparam int PC_W       = 20;
   localparam int PC_LOW_W   = 16;

   // ==========================================================
   // Byte alias codes, as numbered with the remap bit clear
   localparam logic [3:0] B_X_LOW      = 4'h0;
   localparam logic [3:0] B_ACC_LOW    = 4'h1;
   localparam logic [3:0] B_COUNT_C    = 4'h2;
   localparam logic [3:0] B_COUNT_B    = 4'h3;
   localparam logic [3:0] B_REMAP_OFS  = 4'h4;
   localparam logic [3:0] B_NOALIAS_HI = 4'hB;

   // ==========================================================
   // Pair and wide alias codes
   localparam logic [2:0] P_ACC       = 3'h0;
   localparam logic [2:0] P_COUNT     = 3'h1;
   localparam logic [2:0] P_CTX_LOW   = 3'h2;
   localparam logic [2:0] P_CTX_HIGH  = 3'h3;
   localparam logic [2:0] P_FIXED_LO  = 3'h4;
   localparam logic [2:0] P_OFS_SIX   = 3'h6;
   localparam logic [2:0] P_OFS_SEVEN = 3'h7;
   localparam logic [2:0] P_REMAP_OFS = 3'h2;
   localparam logic [1:0] W_VECTOR    = 2'h0;
   localparam logic [1:0] W_USTACK    = 2'h1;
   localparam logic [1:0] W_STR_T     = 2'h2;
   localparam logic [1:0] W_STR_W     = 2'h3;

   // ==========================================================
   // Status word fields
   localparam int REMAP_BIT = 5;
   localparam int BANK_LSB  = 12;
   localparam int HIGH_LSB  = 8;
   localparam int KEEP_LSB  = 12;
   localparam logic [15:0] STATUS_RESET = 16'h0000;

   // ==========================================================
   // Register port map
   localparam int ADDR_W = 8;
   localparam logic [7:0] STATUS_LOW_OFS  = 8'h80;
   localparam logic [7:0] STATUS_HIGH_OFS = 8'h81;
   localparam int RAM_SEL_BIT = 7;

   // ==========================================================
   // Carriers
   typedef enum logic [1:0] {
      BRF_BYTE = 2'b00,
      BRF_PAIR = 2'b01,
      BRF_WIDE = 2'b11
   } brf_width_t;

   typedef enum logic [1:0] {
      AM_INDIRECT      = 2'b00,
      AM_BASED         = 2'b01,
      AM_BASED_INDEXED = 2'b11,
      AM_INDEXED       = 2'b10
   } brf_mode_t;

   typedef enum logic [1:0] {
      OFS_B     = 2'b00,
      OFS_C     = 2'b01,
      OFS_SIX   = 2'b10,
      OFS_SEVEN = 2'b11
   } brf_ofs_t;

   typedef struct packed {
      brf_width_t width;
      logic       by_alias;
      logic [3:0] code;
   } brf_sel_t;

   typedef struct packed {
      logic              en;
      brf_sel_t          sel;
      logic [WIDE_W-1:0] data;
   } brf_wr_t;

   typedef struct packed {
      logic              en;
      logic [WORD_W-1:0] data;
   } brf_stat_t;

   typedef struct packed {
      logic              en;
      logic [PC_W-1:0]   pc;
      logic [BANK_W-1:0] bank;
   } brf_ctx_t;

   typedef struct packed {
      logic en;
      logic use_c;
   } brf_dec_t;

   typedef struct packed {
      logic              en;
      logic [QUAD_W-1:0] data;
   } brf_quad_t;

   typedef struct packed {
      logic       en;
      brf_mode_t  mode;
      logic [1:0] base_src;
      brf_ofs_t   ofs_src;
   } brf_agen_t;

endpackage

// ### verilog/brf_alias_dec.sv
// Alias to absolute register number translation
`timescale 1ns/1ps
module brf_alias_dec (
   input  brf_pkg::brf_sel_t sel_i,
   input  wire logic         remap_i,
   output logic [3:0]        abs_o,
   output logic              illegal_o
);
   import brf_pkg::*;

   // ==========================================================
   // Class of the requested code
   wire       low_alias  = (sel_i.code <= B_COUNT_B);
   wire       no_alias   = (sel_i.code > B_COUNT_B) &&
                           (sel_i.code <= B_NOALIAS_HI);
   wire [2:0] pcode      = sel_i.code[2:0];
   wire       pair_range = ~sel_i.code[3];
   wire       pair_remap = (pcode <= P_COUNT);
   wire       pair_gap   = (pcode == P_CTX_LOW) || (pcode == P_CTX_HIGH);
   wire       wide_range = pair_range && (pcode >= P_FIXED_LO);

   // Byte translation: low aliases shift by four under remap
   wire [3:0] byte_abs = (sel_i.by_alias && low_alias && remap_i) ?
                         sel_i.code + B_REMAP_OFS : sel_i.code;
   wire       byte_bad = sel_i.by_alias && no_alias;

   // Pair translation: accumulator and count pairs shift by two
   wire [2:0] pair_abs = (sel_i.by_alias && pair_remap && remap_i) ?
                         pcode + P_REMAP_OFS : pcode;
   wire       pair_bad = !pair_range ||
                         (sel_i.by_alias && pair_gap);

   // Result selection; wide aliases map identically
   assign abs_o = (sel_i.width == BRF_BYTE) ? byte_abs :
                  {1'b0, pair_abs};
   assign illegal_o = (sel_i.width == BRF_BYTE) ? byte_bad :
                      (sel_i.width == BRF_PAIR) ? pair_bad :
                      (sel_i.width == BRF_WIDE) ? !wide_range :
                      1'b1;

endmodule

// ### verilog/brf_regfile.sv
// Banked general register file with dedicated operand views
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module brf_regfile (
   input  wire logic                 CLK_I,
   input  wire logic                 RST_I,
   input  brf_pkg::brf_sel_t         CORE_RD_I,
   input  wire logic                 CORE_RD_EN_I,
   output logic [brf_pkg::WIDE_W-1:0] CORE_RDATA_O,
   output logic                      SEL_ERR_O,
   input  brf_pkg::brf_wr_t          CORE_WR_I,
   input  brf_pkg::brf_stat_t        STATUS_WR_I,
   output logic [brf_pkg::WORD_W-1:0] STATUS_O,
   input  brf_pkg::brf_ctx_t         CTX_I,
   input  brf_pkg::brf_dec_t         DEC_I,
   output logic                      DEC_NZ_O,
   input  brf_pkg::brf_quad_t        QUAD_WR_I,
   input  brf_pkg::brf_agen_t        AGEN_I,
   output logic [brf_pkg::WIDE_W-1:0] AGEN_BASE_O,
   output logic [brf_pkg::WORD_W-1:0] AGEN_OFS_O,
   output logic                      AGEN_ERR_O,
   output logic [brf_pkg::WORD_W-1:0] ACC_PAIR_O,
   output logic [brf_pkg::DATA_W-1:0] BIT_REG_O,
   output logic [brf_pkg::QUAD_W-1:0] WIDE_RESULT_O,
   output logic [brf_pkg::DATA_W-1:0] COUNT_B_O,
   output logic [brf_pkg::DATA_W-1:0] COUNT_C_O,
   output logic [brf_pkg::WIDE_W-1:0] USER_STACK_O,
   output logic [brf_pkg::WIDE_W-1:0] STRING_PTR_T_O,
   output logic [brf_pkg::WIDE_W-1:0] STRING_PTR_W_O,
   input  wire logic [brf_pkg::ADDR_W-1:0] BUS_ADDR_I,
   input  wire logic [brf_pkg::DATA_W-1:0] BUS_WDATA_I,
   input  wire logic                 BUS_WE_I,
   input  wire logic                 BUS_RE_I,
   output logic [brf_pkg::DATA_W-1:0] BUS_RDATA_O
);
   import brf_pkg::*;

   // ==========================================================
   // Storage
   logic [DATA_W-1:0] gpr_q [BANKS*BYTES];
   logic [DATA_W-1:0] ext_q [BANKS*EXTS];
   logic [WORD_W-1:0] status_q;
   logic [WIDE_W-1:0] rdata_q;
   logic              sel_err_q;
   logic              dec_nz_q;
   logic [DATA_W-1:0] bus_rdata_q;
   logic [WIDE_W-1:0] agen_base_q;
   logic [WORD_W-1:0] agen_ofs_q;
   logic              agen_err_q;

   // Counter byte for a loop or pointer use under the remap bit
   function automatic logic [3:0] count_idx(input logic remap,
                                            input logic use_c);
      logic [3:0] base;
      base = use_c ? B_COUNT_C : B_COUNT_B;
      return remap ? base + B_REMAP_OFS : base;
   endfunction

   // Accumulator and count pair under the remap bit
   function automatic logic [2:0] pair_idx(input logic remap,
                                           input logic [2:0] p);
      return remap ? p + P_REMAP_OFS : p;
   endfunction

   // ==========================================================
   // Current bank and remap, straight from status
   wire [BANK_W-1:0] bank  = status_q[BANK_LSB +: BANK_W];
   wire              remap = status_q[REMAP_BIT];

   // Views of the selected bank
   logic [DATA_W-1:0] cur_byte [BYTES];
   logic [WORD_W-1:0] cur_pair [PAIRS];
   logic [WIDE_W-1:0] cur_wide [EXTS];
   for (genvar i = 0; i < BYTES; i++) begin : g_byte
      assign cur_byte[i] = gpr_q[{bank, IDX_W'(i)}];
   end
   for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      assign cur_pair[p] = {cur_byte[2*p+1], cur_byte[2*p]};
   end
   for (genvar e = 0; e < EXTS; e++) begin : g_wide
      assign cur_wide[e] = {ext_q[{bank, 2'(e)}],
                            cur_pair[e+EXTS]};
   end

   // ==========================================================
   // Alias decoders for the read and the write port
   brf_sel_t   port_sel [2];
   logic [3:0] port_abs [2];
   logic       port_bad [2];
   assign port_sel[0] = CORE_RD_I;
   assign port_sel[1] = CORE_WR_I.sel;
   for (genvar g = 0; g < 2; g++) begin : g_dec
      brf_alias_dec u_dec (
         .sel_i     (port_sel[g]),
         .remap_i   (remap),
         .abs_o     (port_abs[g]),
         .illegal_o (port_bad[g])
      );
   end

   // Read port selection
   wire [3:0]        rd_abs = port_abs[0];
   wire [WIDE_W-1:0] rd_val =
      (CORE_RD_I.width == BRF_BYTE) ? {16'h0000, cur_byte[rd_abs]} :
      (CORE_RD_I.width == BRF_PAIR) ? {8'h00, cur_pair[rd_abs[2:0]]} :
      cur_wide[rd_abs[1:0]];
   wire wr_ok = CORE_WR_I.en && !port_bad[1];
   wire [3:0] wr_abs = port_abs[1];

   // Fixed role indices
   wire [3:0] cnt_sel = count_idx(remap, DEC_I.use_c);
   wire [3:0] cnt_b   = count_idx(remap, 1'b0);
   wire [3:0] cnt_c   = count_idx(remap, 1'b1);
   wire [2:0] acc_p   = pair_idx(remap, P_ACC);
   wire [3:0] x_low   = remap ? B_X_LOW + B_REMAP_OFS : B_X_LOW;

   // Context save words
   wire [WORD_W-1:0] ctx_low  = CTX_I.pc[PC_LOW_W-1:0];
   wire [WORD_W-1:0] ctx_high = {CTX_I.pc[PC_W-1:PC_LOW_W],
                                 status_q[WORD_W-1:KEEP_LSB],
                                 status_q[HIGH_LSB-1:0]};

   // ==========================================================
   // Address operand selection
   wire base_ok = (AGEN_I.mode == AM_INDEXED) ||
                  (AGEN_I.mode != AM_BASED_INDEXED) ||
                  (AGEN_I.base_src == W_VECTOR);
   wire [WIDE_W-1:0] base_val = (AGEN_I.mode == AM_INDEXED) ?
                                24'h00_0000 :
                                cur_wide[AGEN_I.base_src];
   wire ofs_used = AGEN_I.mode[1];
   wire ofs_ok   = !(AGEN_I.mode == AM_INDEXED &&
                     AGEN_I.ofs_src == OFS_C);
   wire [WORD_W-1:0] ofs_val =
      !ofs_used                   ? 16'h0000 :
      (AGEN_I.ofs_src == OFS_B)  ? {8'h00, cur_byte[cnt_b]} :
      (AGEN_I.ofs_src == OFS_C)  ? {8'h00, cur_byte[cnt_c]} :
      (AGEN_I.ofs_src == OFS_SIX) ? cur_pair[P_OFS_SIX] :
      cur_pair[P_OFS_SEVEN];

   // Bus read selection
   wire [DATA_W-1:0] bus_val =
      !BUS_ADDR_I[RAM_SEL_BIT]         ? gpr_q[BUS_ADDR_I[SLOT_W-1:0]] :
      (BUS_ADDR_I == STATUS_LOW_OFS)  ? status_q[HIGH_LSB-1:0] :
      (BUS_ADDR_I == STATUS_HIGH_OFS) ? status_q[WORD_W-1:HIGH_LSB] :
      8'h00;

   // ==========================================================
   // Register array and status updates, later sources win
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         for (int i = 0; i < BANKS*BYTES; i++) gpr_q[i] <= 8'h00;
         for (int i = 0; i < BANKS*EXTS; i++) ext_q[i] <= 8'h00;
         status_q <= STATUS_RESET;
      end else begin
         if (BUS_WE_I && !BUS_ADDR_I[RAM_SEL_BIT]) begin
            gpr_q[BUS_ADDR_I[SLOT_W-1:0]] <= BUS_WDATA_I;
         end
         if (BUS_WE_I && BUS_ADDR_I == STATUS_LOW_OFS) begin
            status_q[HIGH_LSB-1:0] <= BUS_WDATA_I;
         end
         if (BUS_WE_I && BUS_ADDR_I == STATUS_HIGH_OFS) begin
            status_q[WORD_W-1:HIGH_LSB] <= BUS_WDATA_I;
         end
         if (wr_ok && CORE_WR_I.sel.width == BRF_BYTE) begin
            gpr_q[{bank, wr_abs}] <= CORE_WR_I.data[7:0];
         end
         if (wr_ok && CORE_WR_I.sel.width != BRF_BYTE) begin
            gpr_q[{bank, wr_abs[2:0], 1'b0}] <= CORE_WR_I.data[7:0];
            gpr_q[{bank, wr_abs[2:0], 1'b1}] <= CORE_WR_I.data[15:8];
         end
         if (wr_ok && CORE_WR_I.sel.width == BRF_WIDE) begin
            ext_q[{bank, wr_abs[1:0]}] <= CORE_WR_I.data[23:16];
         end
         if (STATUS_WR_I.en) begin
            status_q <= STATUS_WR_I.data;
         end
         if (DEC_I.en) begin
            gpr_q[{bank, cnt_sel}] <= cur_byte[cnt_sel] - 8'h01;
         end
         if (QUAD_WR_I.en) begin
            gpr_q[{bank, acc_p, 1'b0}] <= QUAD_WR_I.data[23:16];
            gpr_q[{bank, acc_p, 1'b1}] <= QUAD_WR_I.data[31:24];
            gpr_q[{bank, P_OFS_SIX, 1'b0}] <= QUAD_WR_I.data[7:0];
            gpr_q[{bank, P_OFS_SIX, 1'b1}] <= QUAD_WR_I.data[15:8];
         end
         if (CTX_I.en) begin
            gpr_q[{CTX_I.bank, P_CTX_LOW, 1'b0}]  <= ctx_low[7:0];
            gpr_q[{CTX_I.bank, P_CTX_LOW, 1'b1}]  <= ctx_low[15:8];
            gpr_q[{CTX_I.bank, P_CTX_HIGH, 1'b0}] <= ctx_high[7:0];
            gpr_q[{CTX_I.bank, P_CTX_HIGH, 1'b1}] <= ctx_high[15:8];
            status_q[BANK_LSB +: BANK_W] <= CTX_I.bank;
         end
      end
   end

   // ==========================================================
   // Registered answers
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rdata_q     <= 24'h00_0000;
         sel_err_q   <= 1'b0;
         dec_nz_q    <= 1'b0;
         bus_rdata_q <= 8'h00;
         agen_base_q <= 24'h00_0000;
         agen_ofs_q  <= 16'h0000;
         agen_err_q  <= 1'b0;
      end else begin
         rdata_q     <= CORE_RD_EN_I ? rd_val : rdata_q;
         sel_err_q   <= (CORE_RD_EN_I && port_bad[0]) ||
                        (CORE_WR_I.en && port_bad[1]);
         dec_nz_q    <= DEC_I.en && (cur_byte[cnt_sel] != 8'h01);
         bus_rdata_q <= BUS_RE_I ? bus_val : 8'h00;
         agen_base_q <= AGEN_I.en ? base_val : agen_base_q;
         agen_ofs_q  <= AGEN_I.en ? ofs_val : agen_ofs_q;
         agen_err_q  <= AGEN_I.en && !(base_ok && ofs_ok);
      end
   end

   // ==========================================================
   // Outputs
   assign CORE_RDATA_O   = rdata_q;
   assign SEL_ERR_O      = sel_err_q;
   assign DEC_NZ_O       = dec_nz_q;
   assign BUS_RDATA_O    = bus_rdata_q;
   assign AGEN_BASE_O    = agen_base_q;
   assign AGEN_OFS_O     = agen_ofs_q;
   assign AGEN_ERR_O     = agen_err_q;
   assign STATUS_O       = status_q;
   // Dedicated role views of the current bank
   assign ACC_PAIR_O     = cur_pair[acc_p];
   assign BIT_REG_O      = cur_byte[x_low];
   assign WIDE_RESULT_O  = {cur_pair[acc_p], cur_pair[P_OFS_SIX]};
   assign COUNT_B_O      = cur_byte[cnt_b];
   assign COUNT_C_O      = cur_byte[cnt_c];
   assign USER_STACK_O   = cur_wide[W_USTACK];
   assign STRING_PTR_T_O = cur_wide[W_STR_T];
   assign STRING_PTR_W_O = cur_wide[W_STR_W];

   // ==========================================================
   // Checks
   wire rd_low_alias = CORE_RD_EN_I && CORE_RD_I.by_alias &&
                       CORE_RD_I.width == BRF_BYTE &&
                       CORE_RD_I.code <= B_COUNT_B;

   a_remap_clear_map: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      rd_low_alias && !remap |-> rd_abs == CORE_RD_I.code)
      else $error("low alias misplaced with remap clear");

   a_remap_set_map: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      rd_low_alias && remap |-> rd_abs == CORE_RD_I.code + B_REMAP_OFS)
      else $error("low alias misplaced with remap set");

   a_fixed_alias_map: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CORE_RD_I.by_alias && CORE_RD_I.width == BRF_BYTE &&
      CORE_RD_I.code > B_NOALIAS_HI |-> rd_abs == CORE_RD_I.code)
      else $error("upper byte alias moved");

   a_read_data_next: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CORE_RD_EN_I ##1 !$past(STATUS_WR_I.en) |->
      CORE_RDATA_O == $past(rd_val))
      else $error("read data not returned next cycle");

   a_ctx_low_save: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CTX_I.en && !STATUS_WR_I.en |=> bank == $past(CTX_I.bank) &&
      cur_pair[P_CTX_LOW] == $past(CTX_I.pc[PC_LOW_W-1:0]))
      else $error("context low save wrong");

   a_ctx_high_save: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      CTX_I.en && !STATUS_WR_I.en |=>
      cur_pair[P_CTX_HIGH] == {$past(CTX_I.pc[PC_W-1:PC_LOW_W]),
                               $past(STATUS_O[WORD_W-1:KEEP_LSB]),
                               $past(STATUS_O[HIGH_LSB-1:0])})
      else $error("context high save wrong");

   a_reset_bank_zero: assert property (
      @(posedge CLK_I)
      RST_I |=> bank == 3'h0 && !remap)
      else $error("reset left a bank selected");

   a_counter_decrement: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      DEC_I.en && !CORE_WR_I.en && !BUS_WE_I && !STATUS_WR_I.en &&
      !CTX_I.en && !QUAD_WR_I.en |=>
      cur_byte[$past(cnt_sel)] == $past(cur_byte[cnt_sel]) - 8'h01 &&
      DEC_NZ_O == ($past(cur_byte[cnt_sel]) != 8'h01))
      else $error("loop counter decrement wrong");

   a_quad_write: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      QUAD_WR_I.en && !CTX_I.en && !STATUS_WR_I.en |=>
      WIDE_RESULT_O == $past(QUAD_WR_I.data))
      else $error("quad result not held");

   a_index_offset_c: assert property (
      @(posedge CLK_I) disable iff (RST_I)
      AGEN_I.en && AGEN_I.mode == AM_INDEXED &&
      AGEN_I.ofs_src == OFS_C |=> AGEN_ERR_O)
      else $error("count c accepted in plain indexed");

endmodule

// ### tb/brf_core.sv
// Core-side model: execution and address logic driving the file
`timescale 1ns/1ps
module brf_core (
   input  wire logic                  clk_i,
   output brf_pkg::brf_sel_t          rd_o,
   output logic                       rd_en_o,
   output brf_pkg::brf_wr_t           wr_o,
   output brf_pkg::brf_stat_t         st_o,
   output brf_pkg::brf_ctx_t          ctx_o,
   output brf_pkg::brf_dec_t          dec_o,
   output brf_pkg::brf_quad_t         quad_o,
   output brf_pkg::brf_agen_t         agen_o,
   output logic [brf_pkg::ADDR_W-1:0] addr_o,
   output logic [brf_pkg::DATA_W-1:0] wdata_o,
   output logic                       we_o,
   output logic                       re_o
);
   import brf_pkg::*;
   // ==========================================================
   // Idle at time zero
   initial begin
      {rd_o, rd_en_o, wr_o, st_o, ctx_o, dec_o, quad_o} = '0;
      {agen_o, addr_o, wdata_o, we_o, re_o} = '0;
   end
   // One request cycle; enables drop at the edge that takes them
   task automatic cyc(input brf_wr_t w = '0, input brf_stat_t s = '0,
         input brf_ctx_t c = '0, input brf_dec_t d = '0,
         input brf_quad_t q = '0, input brf_agen_t g = '0,
         input brf_sel_t r = '0, input logic rd = 1'b0);
      @(posedge clk_i);
      {wr_o, st_o, ctx_o, dec_o, quad_o, agen_o} <= {w, s, c, d, q, g};
      rd_o <= r;
      rd_en_o <= rd;
      @(posedge clk_i);
      {wr_o, st_o, ctx_o, dec_o, quad_o, agen_o} <= '0;
      rd_en_o <= 1'b0;
      #1;
   endtask
   // Register bus cycle; write data shows its inverse once released
   task automatic bus(input logic w, input logic [7:0] a,
         input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      we_o <= w;
      re_o <= ~w;
      @(posedge clk_i);
      {we_o, re_o} <= 2'b00;
      wdata_o <= ~d;
      #1;
   endtask
endmodule

// ### tb/brf_tb_top.sv
// Self-checking bench of the banked general register file
`timescale 1ns/1ps
module banked_general_register_file_tb_top;
   import brf_pkg::*;
   // ==========================================================
   // Nets
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   brf_sel_t    rd;
   brf_wr_t     wr;
   brf_stat_t   st;
   brf_ctx_t    ctx;
   brf_dec_t    dec;
   brf_quad_t   quad;
   brf_agen_t   agen;
   logic        rd_en, we, re, err, nz, aerr;
   logic [7:0]  addr, wdata, brd, bitr, cb, cc;
   logic [15:0] status, acc, aofs;
   logic [23:0] rdata, abase, spw, ustk, spt;
   logic [31:0] wide;
   int          n_mismatch = 0;
   int          checked = 0;
   brf_regfile brf_regfile_inst (
      .CLK_I(clk), .RST_I(rst), .CORE_RD_I(rd), .CORE_RD_EN_I(rd_en),
      .CORE_RDATA_O(rdata), .SEL_ERR_O(err), .CORE_WR_I(wr),
      .STATUS_WR_I(st), .STATUS_O(status), .CTX_I(ctx), .DEC_I(dec),
      .DEC_NZ_O(nz), .QUAD_WR_I(quad), .AGEN_I(agen),
      .AGEN_BASE_O(abase), .AGEN_OFS_O(aofs), .AGEN_ERR_O(aerr),
      .ACC_PAIR_O(acc), .BIT_REG_O(bitr), .WIDE_RESULT_O(wide),
      .COUNT_B_O(cb), .COUNT_C_O(cc), .USER_STACK_O(ustk),
      .STRING_PTR_T_O(spt), .STRING_PTR_W_O(spw), .BUS_ADDR_I(addr),
      .BUS_WDATA_I(wdata), .BUS_WE_I(we), .BUS_RE_I(re), .BUS_RDATA_O(brd)
   );
   brf_core brf_core_inst (
      .clk_i(clk), .rd_o(rd), .rd_en_o(rd_en), .wr_o(wr), .st_o(st),
      .ctx_o(ctx), .dec_o(dec), .quad_o(quad), .agen_o(agen),
      .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re)
   );
   // ==========================================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic put(input brf_width_t w, input logic [3:0] c,
         input logic [23:0] d);
      brf_core_inst.cyc(.w('{1'b1, '{w, 1'b0, c}, d}));
   endtask
   task automatic get(input brf_width_t w, input logic a,
         input logic [3:0] c);
      brf_core_inst.cyc(.r('{w, a, c}), .rd(1'b1));
   endtask
   task automatic final_report;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic ag(input brf_mode_t m, input logic [1:0] b,
         input brf_ofs_t o);
      brf_core_inst.cyc(.g('{1'b1, m, b, o}));
   endtask
   task automatic t_alias;
      int e;
      for (int i = 0; i < 16; i++) begin
         put(BRF_BYTE, 4'(i), 24'(16 + i));
      end
      for (int r = 0; r < 2; r++) begin
         brf_core_inst.cyc(.s('{1'b1, 16'(r << 5)}));
         chk("acc", 32'({8'(17+4*r), 8'(16+4*r)}), 32'(acc));
         chk("bit reg", 32'(16+4*r), 32'(bitr));
         chk("count c", 32'(18+4*r), 32'(cc));
         chk("count b", 32'(19+4*r), 32'(cb));
         for (int c = 0; c < 4; c++) begin
            get(BRF_BYTE, 1'b1, 4'(c));
            chk("alias", 32'(16+4*r+c), 32'(rdata[7:0]));
         end
         get(BRF_PAIR, 1'b1, 4'h1);
         e = 'h1312 + 'h404 * r;
         chk("pair alias", e, 32'(rdata[15:0]));
         get(BRF_PAIR, 1'b1, 4'h2);
         chk("pair gap err", 32'h0000_0001, 32'(err));
         get(BRF_BYTE, 1'b1, 4'hC);
         chk("fixed alias", 32'h0000_001C, 32'(rdata[7:0]));
         get(BRF_BYTE, 1'b1, 4'h9);
         chk("alias err", 32'h0000_0001, 32'(err));
      end
      get(BRF_WIDE, 1'b1, 4'h5);
      chk("wide alias", 32'h0000_1B1A, 32'(rdata));
   endtask
   task automatic t_bank;
      brf_core_inst.cyc(.s('{1'b1, 16'h3000}));
      put(BRF_BYTE, 4'h9, 24'h00_005A);
      brf_core_inst.bus(1'b0, 8'h39, 8'h00);
      chk("ram byte", 32'h0000_005A, 32'(brd));
      brf_core_inst.bus(1'b0, 8'h81, 8'h00);
      chk("status hi", 32'h0000_0030, 32'(brd));
      brf_core_inst.bus(1'b1, 8'h3A, 8'hC3);
      get(BRF_BYTE, 1'b0, 4'hA);
      chk("bank byte", 32'h0000_00C3, 32'(rdata[7:0]));
      brf_core_inst.bus(1'b0, 8'h09, 8'h00);
      chk("bank 0", 32'h0000_0019, 32'(brd));
      brf_core_inst.bus(1'b0, 8'h90, 8'h00);
      chk("unmapped", 32'h0000_0000, 32'(brd));
   endtask
   task automatic t_ctx;
      brf_core_inst.cyc(.s('{1'b1, 16'h5007}));
      brf_core_inst.cyc(.c('{1'b1, 20'hA_BCDE, 3'h2}));
      chk("status", 32'h0000_2007, 32'(status));
      get(BRF_PAIR, 1'b0, 4'h2);
      chk("pc low", 32'h0000_BCDE, 32'(rdata[15:0]));
      get(BRF_PAIR, 1'b0, 4'h3);
      chk("pc top", 32'h0000_A507, 32'(rdata[15:0]));
   endtask
   task automatic t_dec;
      put(BRF_BYTE, 4'h3, 24'h00_0001);
      put(BRF_BYTE, 4'h2, 24'h00_0002);
      brf_core_inst.cyc(.d('{1'b1, 1'b0}));
      chk("nz b", 32'h0000_0000, 32'(nz));
      chk("count b", 32'h0000_0000, 32'(cb));
      brf_core_inst.cyc(.d('{1'b1, 1'b1}));
      chk("nz c", 32'h0000_0001, 32'(nz));
      chk("count c", 32'h0000_0001, 32'(cc));
      brf_core_inst.cyc(.q('{1'b1, 32'h1234_5678}));
      chk("acc", 32'h0000_1234, 32'(acc));
      chk("quad", 32'h1234_5678, wide);
   endtask
   task automatic t_agen;
      put(BRF_WIDE, 4'h4, 24'h12_3456);
      put(BRF_WIDE, 4'h5, 24'h65_4321);
      put(BRF_WIDE, 4'h7, 24'hAB_CDEF);
      chk("str w", 32'h00AB_CDEF, 32'(spw));
      chk("user stack", 32'h0065_4321, 32'(ustk));
      put(BRF_BYTE, 4'h3, 24'h00_0044);
      ag(AM_BASED_INDEXED, 2'd0, OFS_B);
      chk("base", 32'h0012_3456, 32'(abase));
      chk("ofs b", 32'h0000_0044, 32'(aofs));
      chk("agen ok", 32'h0000_0000, 32'(aerr));
      ag(AM_INDEXED, 2'd0, OFS_SIX);
      chk("ofs six", 32'h0000_5678, 32'(aofs));
      chk("indexed base", 32'h0000_0000, 32'(abase));
      ag(AM_INDEXED, 2'd0, OFS_SEVEN);
      chk("ofs seven", 32'h0000_CDEF, 32'(aofs));
      ag(AM_INDEXED, 2'd0, OFS_C);
      chk("ofs c", 32'h0000_0001, 32'(aerr));
      ag(AM_BASED, 2'd1, OFS_B);
      chk("ustk base", 32'h0065_4321, 32'(abase));
      chk("based ofs", 32'h0000_0000, 32'(aofs));
      ag(AM_BASED_INDEXED, 2'd1, OFS_C);
      chk("ustk indexed", 32'h0000_0001, 32'(aerr));
      put(BRF_WIDE, 4'h6, 24'h9A_BCDE);
      chk("str t", 32'h009A_BCDE, 32'(spt));
      ag(AM_INDIRECT, 2'd2, OFS_B);
      chk("str t base", 32'h009A_BCDE, 32'(abase));
   endtask
   // ==========================================================
   // Clock inverts each half period; reset, sequence, hang guard
   always #5 clk = ~clk;
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk("reset st", 32'h0000_0000, 32'(status));
      t_alias();
      t_bank();
      t_ctx();
      t_dec();
      t_agen();
      final_report();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_mismatch++;
      final_report();
   end
endmodule
